// file: inc/cofc_defines.svh
`ifndef COFC_DEFINES_SVH
`define COFC_DEFINES_SVH
// Property identifiers
`define COFC_ID_TK3_SS 8'h0A
`define COFC_ID_CARD_LEAD 8'h0B
`define COFC_ID_CARD_TRAIL 8'h0C
`define COFC_ID_TRK_LEAD 8'h0D
`define COFC_ID_TRK_TRAIL 8'h0E
// Factory defaults
`define COFC_RST_TK3_SS 8'h26
`define COFC_RST_CARD_LEAD 8'h00
`define COFC_RST_CARD_TRAIL 8'h00
`define COFC_RST_TRK_LEAD 8'h00
`define COFC_RST_TRK_TRAIL 8'h00
// Framing settings and tracks
`define COFC_NUM_PROP 5
`define COFC_NUM_TRK 3
`endif

// file: inc/cofc_pkg.sv
`default_nettype none
package cofc_pkg;
  typedef struct packed {
    logic [6:0] code;
    logic [1:0] trk;
    logic last;
  } cofc_trk_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] id;
    logic [7:0] wdata;
  } cofc_prop_req_s;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CARD_LEAD = 7'h02,
    ST_TRK_LEAD = 7'h04,
    ST_SS = 7'h08,
    ST_DATA = 7'h10,
    ST_TRK_TRAIL = 7'h20,
    ST_CARD_TRAIL = 7'h40
  } cofc_state_e;
endpackage : cofc_pkg
`default_nettype wire

// file: src/cofc_framer.sv
// Overview of operation
// - Emit track 3 sentinel for 7-bit track 3
// - Card-leading character precedes all card output
// - Card-trailing character follows all card output
// - Track-leading character precedes each track's data
// - Zero suppresses; 1..127 emits that code
// - Settings persist in non-volatile storage
// - New values apply only after power cycle
// - Track-trailing character follows each track's data
`include "cofc_defines.svh"
`default_nettype none
module cofc_framer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Property get/set port
  input wire cofc_pkg::cofc_prop_req_s prop_req,
  output logic [7:0] prop_rdata,
  output logic prop_err,
  // Non-volatile store: image loaded on power-up, written on set
  input wire logic [8*`COFC_NUM_PROP-1:0] nv_image,
  output logic nv_wr,
  output logic [7:0] nv_wr_id,
  output logic [7:0] nv_wr_data,
  // Card track data in
  input wire logic trk_valid,
  input wire cofc_pkg::cofc_trk_s trk_in,
  input wire logic trk3_sevenbit,
  output logic trk_ready,
  // Character stream out
  output logic [6:0] char_out,
  output logic char_valid,
  input wire logic char_ready
);
  logic [7:0] nv_r [`COFC_NUM_PROP];
  logic [7:0] nv_nxt [`COFC_NUM_PROP];
  // Active copy feeds the framer and only reloads at power-up
  logic [7:0] act_r [`COFC_NUM_PROP];
  logic [7:0] act_nxt [`COFC_NUM_PROP];
  logic loaded_r, loaded_nxt;
  logic [7:0] prop_rdata_r, prop_rdata_nxt;
  logic prop_err_r, prop_err_nxt;
  logic nv_wr_r, nv_wr_nxt;
  logic [7:0] nv_wr_id_r, nv_wr_id_nxt;
  logic [7:0] nv_wr_data_r, nv_wr_data_nxt;
  logic [2:0] idx;
  logic id_ok;
  // Ids outside the table are refused
  assign id_ok = prop_req.id >= `COFC_ID_TK3_SS && prop_req.id <= `COFC_ID_TRK_TRAIL;
  assign idx = 3'(prop_req.id - `COFC_ID_TK3_SS);

  // Stored copy follows sets; active copy latched once per power-up
  always_comb begin
    for (int i = 0; i < `COFC_NUM_PROP; i++) begin
      nv_nxt[i] = nv_r[i];
      act_nxt[i] = act_r[i];
    end
    loaded_nxt = 1'b1;
    prop_rdata_nxt = prop_rdata_r;
    prop_err_nxt = 1'b0;
    nv_wr_nxt = 1'b0;
    nv_wr_id_nxt = nv_wr_id_r;
    nv_wr_data_nxt = nv_wr_data_r;
    // First cycle after reset loads the store image
    if (!loaded_r) begin
      for (int i = 0; i < `COFC_NUM_PROP; i++) begin
        nv_nxt[i] = nv_image[8*i +: 8];
        act_nxt[i] = nv_image[8*i +: 8];
      end
    end else if ((prop_req.wr || prop_req.rd) && !id_ok) begin
      prop_err_nxt = 1'b1;
    end else if (prop_req.wr) begin
      nv_nxt[idx] = prop_req.wdata;
      nv_wr_nxt = 1'b1;
      nv_wr_id_nxt = prop_req.id;
      nv_wr_data_nxt = prop_req.wdata;
    end else if (prop_req.rd) begin
      prop_rdata_nxt = nv_r[idx];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // Factory defaults until the store image is loaded
      nv_r[0] <= `COFC_RST_TK3_SS;
      nv_r[1] <= `COFC_RST_CARD_LEAD;
      nv_r[2] <= `COFC_RST_CARD_TRAIL;
      nv_r[3] <= `COFC_RST_TRK_LEAD;
      nv_r[4] <= `COFC_RST_TRK_TRAIL;
      act_r[0] <= `COFC_RST_TK3_SS;
      act_r[1] <= `COFC_RST_CARD_LEAD;
      act_r[2] <= `COFC_RST_CARD_TRAIL;
      act_r[3] <= `COFC_RST_TRK_LEAD;
      act_r[4] <= `COFC_RST_TRK_TRAIL;
      loaded_r <= 1'b0;
      prop_rdata_r <= 8'h00;
      prop_err_r <= 1'b0;
      nv_wr_r <= 1'b0;
      nv_wr_id_r <= 8'h00;
      nv_wr_data_r <= 8'h00;
    end else begin
      nv_r <= nv_nxt;
      act_r <= act_nxt;
      loaded_r <= loaded_nxt;
      prop_rdata_r <= prop_rdata_nxt;
      prop_err_r <= prop_err_nxt;
      nv_wr_r <= nv_wr_nxt;
      nv_wr_id_r <= nv_wr_id_nxt;
      nv_wr_data_r <= nv_wr_data_nxt;
    end
  end
  // All property port outputs are registered
  assign prop_rdata = prop_rdata_r;
  assign prop_err = prop_err_r;
  assign nv_wr = nv_wr_r;
  assign nv_wr_id = nv_wr_id_r;
  assign nv_wr_data = nv_wr_data_r;

  // Framing sequencer
  cofc_pkg::cofc_state_e st_r, st_nxt;
  logic [6:0] char_r, char_nxt;
  logic cv_r, cv_nxt;
  logic [1:0] trk_r, trk_nxt;
  logic last_r, last_nxt;
  logic busy;
  logic same_trk;
  logic [7:0] ss_sel;
  assign busy = cv_r && !char_ready;
  // Sentinel only on track 3 in seven-bit format
  assign ss_sel = (trk_in.trk == 2'h2 && trk3_sevenbit) ? act_r[0] : 8'h00;
  // A character of the next track waits until this track is closed
  assign same_trk = trk_in.trk == trk_r;
  assign trk_ready = (st_r == cofc_pkg::ST_DATA) && !busy && same_trk;

  // Zero or bit 7 set sends nothing
  function automatic logic emit(input logic [7:0] v);
    emit = v[6:0] != 7'h00 && !v[7];
  endfunction

  always_comb begin
    st_nxt = st_r;
    char_nxt = char_r;
    cv_nxt = cv_r && !char_ready;
    trk_nxt = trk_r;
    last_nxt = last_r;
    // Every state holds while a character is stalled
    if (loaded_r && !busy) begin
      unique case (st_r)
        cofc_pkg::ST_IDLE: begin
          // First track character starts a card
          if (trk_valid) begin
            st_nxt = cofc_pkg::ST_CARD_LEAD;
          end
        end
        // A suppressed character still spends its state's cycle
        cofc_pkg::ST_CARD_LEAD: begin
          cv_nxt = emit(act_r[1]);
          char_nxt = act_r[1][6:0];
          st_nxt = cofc_pkg::ST_TRK_LEAD;
        end
        cofc_pkg::ST_TRK_LEAD: begin
          cv_nxt = emit(act_r[3]);
          char_nxt = act_r[3][6:0];
          st_nxt = cofc_pkg::ST_SS;
        end
        cofc_pkg::ST_SS: begin
          cv_nxt = emit(ss_sel);
          char_nxt = ss_sel[6:0];
          // Track number taken from the track's first character
          trk_nxt = trk_in.trk;
          st_nxt = cofc_pkg::ST_DATA;
        end
        cofc_pkg::ST_DATA: begin
          if (trk_valid && !same_trk) begin
            // New track: close this one first, character stays pending
            st_nxt = cofc_pkg::ST_TRK_TRAIL;
          end else if (trk_valid) begin
            cv_nxt = 1'b1;
            char_nxt = trk_in.code;
            last_nxt = trk_in.last;
            if (trk_in.last) begin
              st_nxt = cofc_pkg::ST_TRK_TRAIL;
            end
          end
        end
        cofc_pkg::ST_TRK_TRAIL: begin
          cv_nxt = emit(act_r[4]);
          char_nxt = act_r[4][6:0];
          // Last character of the card ends it, else the next track follows
          st_nxt = last_r ? cofc_pkg::ST_CARD_TRAIL : cofc_pkg::ST_TRK_LEAD;
        end
        cofc_pkg::ST_CARD_TRAIL: begin
          cv_nxt = emit(act_r[2]);
          char_nxt = act_r[2][6:0];
          last_nxt = 1'b0;
          // Back to idle, ready for the next card
          st_nxt = cofc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= cofc_pkg::ST_IDLE;
      char_r <= 7'h00;
      cv_r <= 1'b0;
      trk_r <= 2'h0;
      last_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      char_r <= char_nxt;
      cv_r <= cv_nxt;
      trk_r <= trk_nxt;
      last_r <= last_nxt;
    end
  end
  // Character outputs come straight from flip-flops
  assign char_out = char_r;
  assign char_valid = cv_r;
endmodule : cofc_framer
`default_nettype wire

// file: verif/cofc_framer_properties.sv
`default_nettype none
module cofc_framer_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports
  input wire cofc_pkg::cofc_prop_req_s prop_req,
  input wire logic prop_err,
  input wire logic nv_wr,
  input wire logic [7:0] nv_wr_id,
  input wire logic [7:0] nv_wr_data,
  input wire logic trk_valid,
  input wire cofc_pkg::cofc_trk_s trk_in,
  input wire logic trk_ready,
  input wire logic [6:0] char_out,
  input wire logic char_valid,
  input wire logic char_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bad, req, stall, take;
  assign bad = prop_req.id < 8'h0A || prop_req.id > 8'h0E;
  assign req = prop_req.wr || prop_req.rd;
  assign stall = char_valid && !char_ready;
  assign take = trk_valid && trk_ready;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_stall_hold: assert property (stall |=> char_valid && $stable(char_out))
    else $error("char lost in stall");
  a_zero_skip: assert property (char_valid |-> char_out != 7'h00)
    else $error("zero char sent");
  a_take_char: assert property (take |=> char_valid && char_out == $past(trk_in.code))
    else $error("track char not passed");
  a_ready_gate: assert property (trk_ready |-> !stall)
    else $error("ready while stalled");
  a_set_store: assert property ($past(nrst) && prop_req.wr && !bad
    |=> nv_wr && {nv_wr_id, nv_wr_data} == $past(prop_req[15:0])) else $error("set not stored");
  a_bad_id: assert property ($past(nrst) && req && bad |=> prop_err && !nv_wr)
    else $error("bad id accepted");
  a_err_cause: assert property (prop_err |-> $past(bad) && $past(req))
    else $error("spurious error");
  a_good_quiet: assert property ($past(nrst) && req && !bad |=> !prop_err)
    else $error("good id refused");
  c_stall: cover property (stall);
  c_set: cover property (nv_wr);
  c_err: cover property (prop_err);
endmodule // cofc_framer_properties
bind cofc_framer cofc_framer_properties u_props (.core_clk(core_clk), .nrst(nrst),
  .prop_req(prop_req), .prop_err(prop_err), .nv_wr(nv_wr), .nv_wr_id(nv_wr_id),
  .nv_wr_data(nv_wr_data), .trk_valid(trk_valid), .trk_in(trk_in), .trk_ready(trk_ready),
  .char_out(char_out), .char_valid(char_valid), .char_ready(char_ready));
`default_nettype wire

// file: verif/cofc_host_model.sv
`default_nettype none
module cofc_host_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic slow,
  // Character stream
  input wire logic [6:0] char_out,
  input wire logic char_valid,
  output logic char_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] rx_q[$];
  logic tog_r = 1'b0;
  // Slow host accepts every other cycle
  assign char_ready = !slow || tog_r;
  always @(posedge core_clk) begin
    tog_r <= !tog_r;
    if (char_valid && char_ready) rx_q.push_back(char_out);
  end
endmodule // cofc_host_model
`default_nettype wire

// file: verif/tb_cofc_framer.sv
`default_nettype none
module tb_cofc_framer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  cofc_pkg::cofc_prop_req_s prop_req = '0;
  cofc_pkg::cofc_trk_s trk_in = '0;
  logic [39:0] nv_image = 40'h0000000026;
  logic trk_valid = 1'b0;
  logic trk3_sevenbit = 1'b1;
  logic slow = 1'b0;
  logic [7:0] prop_rdata, nv_wr_id, nv_wr_data;
  logic prop_err, nv_wr, trk_ready, char_valid, char_ready;
  logic [6:0] char_out;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 core_clk = !core_clk;
  cofc_framer uut (.core_clk(core_clk), .nrst(nrst), .prop_req(prop_req),
    .prop_rdata(prop_rdata), .prop_err(prop_err), .nv_image(nv_image), .nv_wr(nv_wr),
    .nv_wr_id(nv_wr_id), .nv_wr_data(nv_wr_data), .trk_valid(trk_valid), .trk_in(trk_in),
    .trk3_sevenbit(trk3_sevenbit), .trk_ready(trk_ready), .char_out(char_out),
    .char_valid(char_valid), .char_ready(char_ready));
  cofc_host_model host (.core_clk(core_clk), .slow(slow), .char_out(char_out),
    .char_valid(char_valid), .char_ready(char_ready));
  // Store survives power cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (nv_wr && nv_wr_id inside {[8'h0A:8'h0E]}) nv_image[8*(nv_wr_id-8'h0A)+:8] <= nv_wr_data;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pwr();
    @(negedge core_clk) nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic prop(input logic wr, input logic [7:0] id, v, input logic err);
    @(negedge core_clk) prop_req = '{wr, !wr, id, v};
    @(negedge core_clk) prop_req = '0;
    chk({6'h00, prop_err, nv_wr}, {6'h00, err, wr && !err});
    if (!wr && !err) chk(prop_rdata, v);
  endtask
  task automatic card(input logic [1:0] tk[$], input logic [6:0] e[$]);
    host.rx_q.delete();
    trk_valid = 1'b1;
    foreach (tk[i]) begin
      trk_in = '{7'h41 + 7'(i), tk[i], i == tk.size() - 1};
      #1;
      while (trk_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
    end
    trk_valid = 1'b0;
    for (int k = 0; k < 60 && host.rx_q.size() < e.size(); k++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    chk(8'(host.rx_q.size()), 8'(e.size()));
    foreach (e[i]) chk({1'b0, host.rx_q[i]}, {1'b0, e[i]});
  endtask
  task automatic t_defaults();
    for (int id = 9; id <= 15; id++)
      prop(1'b0, 8'(id), id == 10 ? 8'h26 : 8'h00, id < 10 || id > 14);
  endtask
  task automatic t_pending();
    for (int i = 0; i < 4; i++) prop(1'b1, 8'h0B + 8'(i), 8'h42 + 8'(i), 1'b0);
    prop(1'b1, 8'h10, 8'h55, 1'b1);
    prop(1'b0, 8'h0C, 8'h43, 1'b0);
    slow = 1'b1;
    card({2'h2, 2'h2}, {7'h26, 7'h41, 7'h42});
    slow = 1'b0;
  endtask
  task automatic t_cycled();
    pwr();
    card({2'h2, 2'h2}, {7'h42, 7'h44, 7'h26, 7'h41, 7'h42, 7'h45, 7'h43});
  endtask
  task automatic t_zero();
    prop(1'b1, 8'h0D, 8'h00, 1'b0);
    prop(1'b1, 8'h0A, 8'h00, 1'b0);
    prop(1'b1, 8'h0E, 8'h80, 1'b0);
    pwr();
    card({2'h2, 2'h2}, {7'h42, 7'h41, 7'h42, 7'h43});
  endtask
  task automatic t_tracks();
    logic [6:0] e[$];
    prop(1'b1, 8'h0A, 8'h26, 1'b0);
    prop(1'b1, 8'h0D, 8'h44, 1'b0);
    prop(1'b1, 8'h0E, 8'h45, 1'b0);
    pwr();
    e = {7'h42, 7'h44, 7'h41, 7'h42, 7'h45};
    e = {e, 7'h44, 7'h26, 7'h43, 7'h45, 7'h43};
    card({2'h0, 2'h0, 2'h2}, e);
    trk3_sevenbit = 1'b0;
    card({2'h2}, {7'h42, 7'h44, 7'h41, 7'h45, 7'h43});
    trk3_sevenbit = 1'b1;
  endtask
  initial begin
    pwr();
    t_defaults();
    t_pending();
    t_cycled();
    t_zero();
    t_tracks();
    end_of_test();
  end
endmodule // tb_cofc_framer
`default_nettype wire
